// ===== rtl/ltem_pkg.sv
// constants for the transmit-side link event monitor: event codes,
// qualifier bits, flit class codes, register map and status layout.
// assumes a single 40 MHz flit clock and a plain strobe register port.
//
// Operation
// - code 0x0d adds one per cycle spent in the half-width state.
// - half-width state runs half the lanes, ten bits per transfer unit.
// - edge detect on half-width event counts entries, not cycles.
// - edge results are flagged invalid once sleep-state cycles exceed zero.
// - code 0x0c adds one per cycle in the full-power state.
// - full-power cycles include half-width cycles.
// - edge detect on full-power counts entries; training exits are not seen.
// - transmit power state is tracked on its own, apart from receive.
// - code 0x05 counts flits that skip the transmit buffer, one per cycle.
// - code 0x06 counts cycles where the transmit buffer holds an entry.
// - buffer is expected in use only in half-width state or during retry.
// - group zero, code 0x00 without extra select, adds up to two flits.
// - a flit is 80 bits, four transfer units of twenty in full width.
// - half width uses ten-bit units, so eight units per flit.
// - a 64-byte line is nine flits, one header and eight data.
// - group zero data qualifier counts payload flits, not packet headers.
// - group zero value 0x04 counts non-null non-data flits with headers.
// - group one, code 0x00 with extra select, adds up to two flits.
// - group one value 0x01 counts snoop requests, not snoop responses.
// - group one 0x02 home requests, 0x04 non-requests, 0x06 all home.
// - group one 0x08 payload, 0x10 headers, 0x18 both; no bypass data.

package ltem_pkg;

  // event codes
  localparam logic [7:0] EV_FLITS     = 8'h00;
  localparam logic [7:0] EV_SKIP      = 8'h05;
  localparam logic [7:0] EV_OCCUPIED  = 8'h06;
  localparam logic [7:0] EV_FULL_PWR  = 8'h0c;
  localparam logic [7:0] EV_HALF_PWR  = 8'h0d;

  // group zero qualifier bits
  localparam int G0_DATA_BIT    = 1;
  localparam int G0_NONDATA_BIT = 2;
  // group one qualifier bits
  localparam int G1_SNOOP_BIT   = 0;
  localparam int G1_HOME_REQ    = 1;
  localparam int G1_HOME_NONREQ = 2;
  localparam int G1_RESP_DATA   = 3;
  localparam int G1_RESP_HDR    = 4;

  // flit class codes on each transmit slot
  localparam logic [3:0] FC_NULL       = 4'h0;
  localparam logic [3:0] FC_SNOOP_REQ  = 4'h1;
  localparam logic [3:0] FC_HOME_REQ   = 4'h2;
  localparam logic [3:0] FC_HOME_NRQ   = 4'h3;
  localparam logic [3:0] FC_RESP_HDR   = 4'h4;
  localparam logic [3:0] FC_RESP_DATA  = 4'h5;
  localparam logic [3:0] FC_NCOH_HDR   = 4'h6;
  localparam logic [3:0] FC_NCOH_DATA  = 4'h7;
  localparam logic [3:0] FC_OTHER_PROT = 4'h8;

  localparam int SLOTS = 2;

  // register byte addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_COUNT  = 8'h04;
  localparam logic [7:0] A_SLEEP  = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0c;

  // control field positions
  localparam int CT_EV_LO   = 0;
  localparam int CT_QUAL_LO = 8;
  localparam int CT_EDGE    = 18;
  localparam int CT_XSEL    = 21;
  localparam int CT_EN      = 22;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // status field positions
  localparam int ST_HALF    = 0;
  localparam int ST_FULL    = 1;
  localparam int ST_INVALID = 2;
  localparam int ST_BUF_EXP = 3;
  localparam int ST_UNIT_LO = 4;
  localparam int ST_BITS_LO = 8;
  localparam int ST_LINE_LO = 16;

  // link framing figures
  localparam logic [3:0] UNITS_FULL    = 4'h4;
  localparam logic [3:0] UNITS_HALF    = 4'h8;
  localparam logic [4:0] UNIT_BITS_FUL = 5'h14;
  localparam logic [4:0] UNIT_BITS_HLF = 5'h0a;
  localparam logic [3:0] LINE_FLITS    = 4'h9;

endpackage

// ===== rtl/ltem_top.sv
// transmit-side link event monitor: selects one event, counts it, and
// exposes control, count, sleep-cycle and status words on a strobe port.
// assumes all link status inputs are synchronous to i_clk (flit clock).
//
// Implementation choices: the address map and the strobed register port.

`timescale 1ns/10ps
`default_nettype none

module ltem_top (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // transmit power state
  input  wire logic        i_tx_full_power,
  input  wire logic        i_tx_half_width,
  input  wire logic        i_tx_sleep,
  // transmit buffer activity
  input  wire logic        i_tx_buf_skip,
  input  wire logic        i_tx_buf_occupied,
  input  wire logic        i_link_retry,
  // transmitted flits, two slots
  input  wire logic [1:0]  i_flit_valid,
  input  wire logic [3:0]  i_flit_class0,
  input  wire logic [3:0]  i_flit_class1,
  // status
  output logic             o_edge_invalid
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] count;
    logic [31:0] sleep_cnt;
    logic        prev_cond;
    logic        invalid;
    logic [31:0] rdata;
  } ltem_state_t;

  ltem_state_t s_q;
  ltem_state_t s_d;

  // group zero class mask of one flit
  function automatic logic [7:0] g0_bits(input logic [3:0] fc);
    logic [7:0] m;
    m = 8'h00;
    case (fc)
      ltem_pkg::FC_RESP_DATA,
      ltem_pkg::FC_NCOH_DATA: m[ltem_pkg::G0_DATA_BIT] = 1'b1;
      ltem_pkg::FC_NULL:     m = 8'h00;
      default:               m[ltem_pkg::G0_NONDATA_BIT] = 1'b1;
    endcase
    return m;
  endfunction

  // group one class mask of one flit
  function automatic logic [7:0] g1_bits(input logic [3:0] fc);
    logic [7:0] m;
    m = 8'h00;
    case (fc)
      ltem_pkg::FC_SNOOP_REQ: m[ltem_pkg::G1_SNOOP_BIT] = 1'b1;
      ltem_pkg::FC_HOME_REQ:  m[ltem_pkg::G1_HOME_REQ] = 1'b1;
      ltem_pkg::FC_HOME_NRQ:  m[ltem_pkg::G1_HOME_NONREQ] = 1'b1;
      ltem_pkg::FC_RESP_DATA: m[ltem_pkg::G1_RESP_DATA] = 1'b1;
      ltem_pkg::FC_RESP_HDR:  m[ltem_pkg::G1_RESP_HDR] = 1'b1;
      default:                m = 8'h00;
    endcase
    return m;
  endfunction

  // control fields
  logic [7:0] ev_code;
  logic [7:0] qual;
  logic       edge_en;
  logic       xsel;
  logic       cnt_en;
  assign ev_code = s_q.ctrl[ltem_pkg::CT_EV_LO +: 8];
  assign qual    = s_q.ctrl[ltem_pkg::CT_QUAL_LO +: 8];
  assign edge_en = s_q.ctrl[ltem_pkg::CT_EDGE];
  assign xsel    = s_q.ctrl[ltem_pkg::CT_XSEL];
  assign cnt_en  = s_q.ctrl[ltem_pkg::CT_EN];

  // per-slot qualifier match, any selected class counts once
  logic [3:0]           slot_class [ltem_pkg::SLOTS];
  logic [ltem_pkg::SLOTS-1:0] slot_hit;
  assign slot_class[0] = i_flit_class0;
  assign slot_class[1] = i_flit_class1;

  genvar gi;
  generate
    for (gi = 0; gi < ltem_pkg::SLOTS; gi++) begin : g_slot
      assign slot_hit[gi] = i_flit_valid[gi] &&
        (|(qual & (xsel ? g1_bits(slot_class[gi])
                        : g0_bits(slot_class[gi]))));
    end
  endgenerate

  // full-power level counts half-width cycles too; training exits drop it
  logic full_level;
  assign full_level = i_tx_full_power | i_tx_half_width;

  // selected condition and per-cycle increment
  logic       cond;
  logic [1:0] inc;
  always_comb begin
    cond = 1'b0;
    inc  = 2'd0;
    case (ev_code)
      ltem_pkg::EV_HALF_PWR: begin
        cond = i_tx_half_width;
        inc  = {1'b0, cond};
      end
      ltem_pkg::EV_FULL_PWR: begin
        cond = full_level;
        inc  = {1'b0, cond};
      end
      ltem_pkg::EV_SKIP: begin
        cond = i_tx_buf_skip;
        inc  = {1'b0, cond};
      end
      ltem_pkg::EV_OCCUPIED: begin
        cond = i_tx_buf_occupied;
        inc  = {1'b0, cond};
      end
      ltem_pkg::EV_FLITS: begin
        inc  = {1'b0, slot_hit[0]} + {1'b0, slot_hit[1]};
        cond = |slot_hit;
      end
      default: begin
        cond = 1'b0;
        inc  = 2'd0;
      end
    endcase
  end

  // status word, unit count and unit width follow the power state; line flits fixed
  logic [31:0] status;
  always_comb begin
    status = 32'h0000_0000;
    status[ltem_pkg::ST_HALF]    = i_tx_half_width;
    status[ltem_pkg::ST_FULL]    = full_level;
    status[ltem_pkg::ST_INVALID] = s_q.invalid;
    status[ltem_pkg::ST_BUF_EXP] = i_tx_half_width | i_link_retry;
    status[ltem_pkg::ST_UNIT_LO +: 4] = i_tx_half_width ?
      ltem_pkg::UNITS_HALF : ltem_pkg::UNITS_FULL;
    status[ltem_pkg::ST_BITS_LO +: 5] = i_tx_half_width ?
      ltem_pkg::UNIT_BITS_HLF : ltem_pkg::UNIT_BITS_FUL;
    status[ltem_pkg::ST_LINE_LO +: 4] = ltem_pkg::LINE_FLITS;
  end

  // next-state logic: register writes, counting, read data
  always_comb begin
    s_d = s_q;
    s_d.prev_cond = cond;
    // edge mode adds one on a rising condition only
    if (cnt_en) begin
      if (edge_en) begin
        s_d.count = s_q.count + {31'd0, cond & ~s_q.prev_cond};
      end else begin
        s_d.count = s_q.count + {30'd0, inc};
      end
    end
    if (i_tx_sleep) begin
      s_d.sleep_cnt = s_q.sleep_cnt + 32'h0000_0001;
    end
    // edge results stop being trustworthy after any sleep cycle
    s_d.invalid = edge_en && (s_q.sleep_cnt != 32'h0000_0000);
    if (i_wr) begin
      case (i_addr)
        ltem_pkg::A_CTRL:  s_d.ctrl = i_wdata;
        ltem_pkg::A_COUNT: s_d.count = i_wdata;
        // a sleep cycle in the clearing cycle still counts
        ltem_pkg::A_SLEEP: s_d.sleep_cnt = {31'h0000_0000, i_tx_sleep};
        default:           s_d.ctrl = s_q.ctrl;
      endcase
    end
    s_d.rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        ltem_pkg::A_CTRL:   s_d.rdata = s_q.ctrl;
        ltem_pkg::A_COUNT:  s_d.rdata = s_q.count;
        ltem_pkg::A_SLEEP:  s_d.rdata = s_q.sleep_cnt;
        ltem_pkg::A_STATUS: s_d.rdata = status;
        default:            s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata        = s_q.rdata;
  assign o_edge_invalid = s_q.invalid;

  logic cnt_wr;
  assign cnt_wr = i_wr && (i_addr == ltem_pkg::A_COUNT);

  // half-width cycles add exactly one
  chk_half_cycle_add: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && !edge_en && ev_code == ltem_pkg::EV_HALF_PWR && i_tx_half_width
     && !cnt_wr) |=> s_q.count == $past(s_q.count) + 32'd1)
    else $error("half-width cycle not counted");

  // full-power event also counts half-width cycles
  chk_full_incl_half: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && !edge_en && ev_code == ltem_pkg::EV_FULL_PWR &&
     i_tx_half_width && !i_tx_full_power && !cnt_wr)
    |=> s_q.count == $past(s_q.count) + 32'd1)
    else $error("full-power count missed half-width cycle");

  // edge mode holds the count while the state persists
  chk_edge_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && edge_en && ev_code == ltem_pkg::EV_HALF_PWR && !cnt_wr &&
     i_tx_half_width && s_q.prev_cond) |=> $stable(s_q.count))
    else $error("edge mode counted a held state");

  // a half-width cycle after a non-half-width cycle adds one entry in edge mode
  chk_edge_entry: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && edge_en && ev_code == ltem_pkg::EV_HALF_PWR && !cnt_wr &&
     !i_tx_half_width) ##1 (i_tx_half_width && !cnt_wr && cnt_en &&
     edge_en && ev_code == ltem_pkg::EV_HALF_PWR)
    |=> s_q.count == $past(s_q.count) + 32'd1)
    else $error("edge entry not counted once");

  // skipped flit adds one
  chk_skip_count: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && !edge_en && ev_code == ltem_pkg::EV_SKIP && !cnt_wr)
    |=> s_q.count == $past(s_q.count) + {31'd0, $past(i_tx_buf_skip)})
    else $error("buffer skip count wrong");

  // two data flits add two in group zero
  chk_g0_two_data: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && !edge_en && !xsel && ev_code == ltem_pkg::EV_FLITS &&
     qual[ltem_pkg::G0_DATA_BIT] && i_flit_valid == 2'b11 && !cnt_wr &&
     i_flit_class0 == ltem_pkg::FC_RESP_DATA &&
     i_flit_class1 == ltem_pkg::FC_NCOH_DATA)
    |=> s_q.count == $past(s_q.count) + 32'd2)
    else $error("group zero data flits miscounted");

  // snoop responses are not snoop requests
  chk_g1_snoop_only: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (xsel && ev_code == ltem_pkg::EV_FLITS && qual == 8'h01 && !edge_en &&
     !cnt_wr && i_flit_class0 == ltem_pkg::FC_HOME_NRQ &&
     i_flit_class1 == ltem_pkg::FC_HOME_NRQ) |=> $stable(s_q.count))
    else $error("snoop response counted as snoop");

  // edge results marked invalid after sleep cycles
  chk_edge_invalid: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (edge_en && s_q.sleep_cnt != 32'h0000_0000 && !i_wr) ##1 edge_en
    |-> o_edge_invalid)
    else $error("edge result not flagged invalid");

  // full-power cycles add exactly one
  chk_full_cycle_add: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && !edge_en && ev_code == ltem_pkg::EV_FULL_PWR &&
     i_tx_full_power && !cnt_wr) |=> s_q.count == $past(s_q.count) + 32'd1)
    else $error("full-power cycle not counted");

  // half-width event never adds more than one
  chk_half_max_one: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && ev_code == ltem_pkg::EV_HALF_PWR && !cnt_wr)
    |=> (s_q.count - $past(s_q.count)) <= 32'd1)
    else $error("half-width event added more than one");

  // occupied buffer cycles add one each
  chk_occ_cycle_add: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && !edge_en && ev_code == ltem_pkg::EV_OCCUPIED && !cnt_wr)
    |=> s_q.count == $past(s_q.count) + {31'd0, $past(i_tx_buf_occupied)})
    else $error("occupied buffer count wrong");

  // flit events never add more than two
  chk_flit_max_two: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && ev_code == ltem_pkg::EV_FLITS && !cnt_wr)
    |=> (s_q.count - $past(s_q.count)) <= 32'd2)
    else $error("flit event added more than two");

  // group zero data leaves out the packet header
  chk_g0_data_hdr: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && !edge_en && !xsel && ev_code == ltem_pkg::EV_FLITS &&
     qual == 8'h02 && i_flit_valid == 2'b11 && !cnt_wr &&
     i_flit_class0 == ltem_pkg::FC_RESP_DATA &&
     i_flit_class1 == ltem_pkg::FC_RESP_HDR)
    |=> s_q.count == $past(s_q.count) + 32'd1)
    else $error("group zero data counted a header");

  // group zero non-data counts a lone protocol flit
  chk_g0_nondata: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && !edge_en && !xsel && ev_code == ltem_pkg::EV_FLITS &&
     qual == 8'h04 && i_flit_valid == 2'b01 && !cnt_wr &&
     i_flit_class0 != ltem_pkg::FC_NULL &&
     i_flit_class0 != ltem_pkg::FC_RESP_DATA &&
     i_flit_class0 != ltem_pkg::FC_NCOH_DATA)
    |=> s_q.count == $past(s_q.count) + 32'd1)
    else $error("group zero non-data flit missed");

  // all-home qualifier takes the request, not the snoop
  chk_g1_home_all: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && !edge_en && xsel && ev_code == ltem_pkg::EV_FLITS &&
     qual == 8'h06 && i_flit_valid == 2'b11 && !cnt_wr &&
     i_flit_class0 == ltem_pkg::FC_SNOOP_REQ &&
     i_flit_class1 == ltem_pkg::FC_HOME_REQ)
    |=> s_q.count == $past(s_q.count) + 32'd1)
    else $error("home flits miscounted");

  // response header and payload both count
  chk_g1_resp_both: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && !edge_en && xsel && ev_code == ltem_pkg::EV_FLITS &&
     qual == 8'h18 && i_flit_valid == 2'b11 && !cnt_wr &&
     i_flit_class0 == ltem_pkg::FC_RESP_DATA &&
     i_flit_class1 == ltem_pkg::FC_RESP_HDR)
    |=> s_q.count == $past(s_q.count) + 32'd2)
    else $error("response flits miscounted");

  // non-coherent flits never count as responses
  chk_g1_ncoh_excl: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (xsel && ev_code == ltem_pkg::EV_FLITS && qual == 8'h18 && !edge_en &&
     !cnt_wr && i_flit_class0 != ltem_pkg::FC_RESP_DATA &&
     i_flit_class0 != ltem_pkg::FC_RESP_HDR &&
     i_flit_class1 != ltem_pkg::FC_RESP_DATA &&
     i_flit_class1 != ltem_pkg::FC_RESP_HDR) |=> $stable(s_q.count))
    else $error("non-response flit counted");

  // edge mode adds nothing while the condition is false
  chk_edge_no_fall: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (cnt_en && edge_en && !cond && !cnt_wr) |=> $stable(s_q.count))
    else $error("edge mode counted a false cycle");

  // a disabled counter holds its value
  chk_count_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (!cnt_en && !cnt_wr) |=> $stable(s_q.count))
    else $error("disabled counter moved");

  // a count write wins over a same-cycle event
  chk_count_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    cnt_wr |=> s_q.count == $past(i_wdata))
    else $error("count write not taken");

  // each sleep cycle adds one to the sleep count
  chk_sleep_count: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_tx_sleep && !i_wr)
    |=> s_q.sleep_cnt == $past(s_q.sleep_cnt) + 32'd1)
    else $error("sleep cycle not counted");

  // read data stands only after a read strobe
  chk_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data without a read");

  // buffer-expected bit follows half width or retry
  chk_buf_expected: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_rd && i_addr == ltem_pkg::A_STATUS)
    |=> o_rdata[ltem_pkg::ST_BUF_EXP] ==
        ($past(i_tx_half_width) | $past(i_link_retry)))
    else $error("buffer-expected bit wrong");

endmodule

`default_nettype wire

// ===== test/link_tx_event_monitor_test.sv
// self-checking bench for the transmit-side link event monitor.
// assumes ltem_pkg and ltem_top are compiled first; one 40 MHz clock.

`timescale 1ns/10ps
`default_nettype none

module link_tx_event_monitor_test;
  logic        i_clk             = 1'b0;
  logic        i_arst_n          = 1'b0;
  logic [7:0]  i_addr            = 8'h00;
  logic [31:0] i_wdata           = 32'h0000_0000;
  logic        i_wr              = 1'b0;
  logic        i_rd              = 1'b0;
  logic [31:0] o_rdata;
  logic        i_tx_full_power   = 1'b0;
  logic        i_tx_half_width   = 1'b0;
  logic        i_tx_sleep        = 1'b0;
  logic        i_tx_buf_skip     = 1'b0;
  logic        i_tx_buf_occupied = 1'b0;
  logic        i_link_retry      = 1'b0;
  logic [1:0]  i_flit_valid      = 2'b00;
  logic [3:0]  i_flit_class0     = 4'h0;
  logic [3:0]  i_flit_class1     = 4'h0;
  logic        o_edge_invalid;
  logic [31:0] rv;
  int          n_fail            = 0;
  int          tests_run         = 0;

  // flit slots per cycle: {valid, class0, class1}
  localparam logic [9:0] SEQ [5] = '{10'h354, 10'h312, 10'h337,
                                     10'h306, 10'h185};
  // {extra select, qualifier} and expected flit totals for SEQ
  localparam logic [8:0] CFG [10] = '{9'h002, 9'h004, 9'h006, 9'h101,
    9'h102, 9'h104, 9'h106, 9'h108, 9'h110, 9'h118};
  localparam logic [3:0] FEXP [10] = '{4'h2, 4'h6, 4'h8, 4'h1, 4'h1,
    4'h1, 4'h2, 4'h1, 4'h1, 4'h2};

  ltem_top DUT (
    .i_clk             (i_clk),
    .i_arst_n          (i_arst_n),
    .i_addr            (i_addr),
    .i_wdata           (i_wdata),
    .i_wr              (i_wr),
    .i_rd              (i_rd),
    .o_rdata           (o_rdata),
    .i_tx_full_power   (i_tx_full_power),
    .i_tx_half_width   (i_tx_half_width),
    .i_tx_sleep        (i_tx_sleep),
    .i_tx_buf_skip     (i_tx_buf_skip),
    .i_tx_buf_occupied (i_tx_buf_occupied),
    .i_link_retry      (i_link_retry),
    .i_flit_valid      (i_flit_valid),
    .i_flit_class0     (i_flit_class0),
    .i_flit_class1     (i_flit_class1),
    .o_edge_invalid    (o_edge_invalid)
  );

  // 25 ns flit clock
  always #12.5 i_clk = ~i_clk;

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // control word with enable set
  function automatic logic [31:0] mk(input logic [7:0] ev,
      input logic [7:0] ql, input logic ed, input logic xs);
    mk = 32'h0000_0000;
    mk[ltem_pkg::CT_EV_LO +: 8] = ev;
    mk[ltem_pkg::CT_QUAL_LO +: 8] = ql;
    mk[ltem_pkg::CT_EDGE] = ed;
    mk[ltem_pkg::CT_XSEL] = xs;
    mk[ltem_pkg::CT_EN] = 1'b1;
  endfunction

  // select an event and clear the count
  task automatic sel(input logic [31:0] c);
    wr(ltem_pkg::A_CTRL, c);
    wr(ltem_pkg::A_COUNT, 32'h0000_0000);
  endtask

  // three cycles in half width, status read while there
  task automatic half_cycles();
    sel(mk(ltem_pkg::EV_HALF_PWR, 8'h00, 1'b0, 1'b0));
    @(posedge i_clk);
    i_tx_half_width <= 1'b1;
    i_tx_full_power <= 1'b1;
    rd(ltem_pkg::A_STATUS, rv);
    check(rv, 32'h0009_0a8b);
    @(posedge i_clk);
    {i_tx_half_width, i_tx_full_power} <= 2'b00;
    rd(ltem_pkg::A_COUNT, rv);
    check(rv, 32'h0000_0003);
  endtask

  // two full cycles then three half cycles, all counted as full
  task automatic full_cycles();
    sel(mk(ltem_pkg::EV_FULL_PWR, 8'h00, 1'b0, 1'b0));
    @(posedge i_clk);
    i_tx_full_power <= 1'b1;
    repeat (2) @(posedge i_clk);
    {i_tx_half_width, i_tx_full_power} <= 2'b10;
    repeat (3) @(posedge i_clk);
    {i_tx_half_width, i_tx_full_power} <= 2'b00;
    rd(ltem_pkg::A_COUNT, rv);
    check(rv, 32'h0000_0005);
  endtask

  // three entries of two cycles each count three with edge detect
  task automatic edge_count(input logic [7:0] ev);
    sel(mk(ev, 8'h00, 1'b1, 1'b0));
    repeat (3) begin
      @(posedge i_clk);
      {i_tx_half_width, i_tx_full_power} <= 2'b11;
      repeat (2) @(posedge i_clk);
      {i_tx_half_width, i_tx_full_power} <= 2'b00;
    end
    rd(ltem_pkg::A_COUNT, rv);
    check(rv, 32'h0000_0003);
    check({31'h0000_0000, o_edge_invalid}, 32'h0000_0000);
  endtask

  // skip high three cycles, buffer occupied one, for both events
  task automatic buffer_events();
    for (int k = 0; k < 2; k++) begin
      sel(mk(k == 0 ? ltem_pkg::EV_SKIP : ltem_pkg::EV_OCCUPIED,
             8'h00, 1'b0, 1'b0));
      @(posedge i_clk);
      {i_tx_buf_skip, i_tx_buf_occupied, i_link_retry} <= 3'b111;
      @(posedge i_clk);
      i_tx_buf_occupied <= 1'b0;
      repeat (2) @(posedge i_clk);
      {i_tx_buf_skip, i_link_retry} <= 2'b00;
      rd(ltem_pkg::A_COUNT, rv);
      check(rv, k == 0 ? 32'h0000_0003 : 32'h0000_0001);
    end
  endtask

  // every qualifier of both flit groups over one flit sequence
  task automatic flit_groups();
    logic [31:0] ex;
    for (int i = 0; i < 10; i++) begin
      sel(mk(ltem_pkg::EV_FLITS, CFG[i][7:0], 1'b0, CFG[i][8]));
      for (int j = 0; j < 5; j++) begin
        @(posedge i_clk);
        {i_flit_valid, i_flit_class0, i_flit_class1} <= SEQ[j];
      end
      @(posedge i_clk);
      i_flit_valid <= 2'b00;
      rd(ltem_pkg::A_COUNT, rv);
      ex = {28'h000_0000, FEXP[i]};
      check(rv, ex);
    end
  endtask

  // two data flits per cycle for two cycles add four in group zero
  task automatic g0_two_data();
    sel(mk(ltem_pkg::EV_FLITS, 8'h02, 1'b0, 1'b0));
    @(posedge i_clk);
    {i_flit_valid, i_flit_class0, i_flit_class1} <=
      {2'b11, ltem_pkg::FC_RESP_DATA, ltem_pkg::FC_NCOH_DATA};
    repeat (2) @(posedge i_clk);
    i_flit_valid <= 2'b00;
    rd(ltem_pkg::A_COUNT, rv);
    check(rv, 32'h0000_0004);
  endtask

  // one sleep cycle with edge detect on flags edge results invalid
  task automatic edge_invalid();
    sel(mk(ltem_pkg::EV_HALF_PWR, 8'h00, 1'b1, 1'b0));
    @(posedge i_clk);
    i_tx_sleep <= 1'b1;
    @(posedge i_clk);
    i_tx_sleep <= 1'b0;
    rd(ltem_pkg::A_SLEEP, rv);
    check(rv, 32'h0000_0001);
    check({31'h0000_0000, o_edge_invalid}, 32'h0000_0001);
    wr(ltem_pkg::A_SLEEP, 32'h0000_0000);
    rd(ltem_pkg::A_STATUS, rv);
    check(rv, 32'h0009_1440);
    check({31'h0000_0000, o_edge_invalid}, 32'h0000_0000);
  endtask

  // count wrap, read-only status, unmapped read
  task automatic reg_access();
    sel(mk(ltem_pkg::EV_OCCUPIED, 8'h00, 1'b0, 1'b0));
    wr(ltem_pkg::A_COUNT, 32'hffff_ffff);
    @(posedge i_clk);
    i_tx_buf_occupied <= 1'b1;
    @(posedge i_clk);
    i_tx_buf_occupied <= 1'b0;
    rd(ltem_pkg::A_COUNT, rv);
    check(rv, 32'h0000_0000);
    @(posedge i_clk);
    i_link_retry <= 1'b1;
    wr(ltem_pkg::A_STATUS, 32'hffff_ffff);
    rd(ltem_pkg::A_STATUS, rv);
    check(rv, 32'h0009_1448);
    @(posedge i_clk);
    i_link_retry <= 1'b0;
    rd(8'h10, rv);
    check(rv, 32'h0000_0000);
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // main sequence after an 8-cycle reset
  initial begin
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(ltem_pkg::A_CTRL, rv);
    check(rv, ltem_pkg::CTRL_RST);
    rd(ltem_pkg::A_STATUS, rv);
    check(rv, 32'h0009_1440);
    half_cycles();
    full_cycles();
    edge_count(ltem_pkg::EV_HALF_PWR);
    edge_count(ltem_pkg::EV_FULL_PWR);
    buffer_events();
    flit_groups();
    g0_two_data();
    edge_invalid();
    reg_access();
    report_and_stop();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge i_clk);
    n_fail++;
    report_and_stop();
  end
endmodule

`default_nettype wire
